// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tic_pkg::*;

  logic        i_mclk;
  logic        i_sys_rst;
  logic        i_xtal = 1'b0;
  sfr_req_s    i_sfr;
  logic [7:0]  o_sfr_rdata;
  logic        i_irq_enable;
  logic        i_power_down;
  logic        o_irq;
  logic        o_wake;
  int          fails;
  int          cmp_count;

  // Address, write data, expected read back
  localparam logic [23:0] ROWS [7] = '{24'ha27f7f, 24'ha33b3b, 24'ha43b3b, 24'ha51717,
                                       24'ha6ffff, 24'ha18000, 24'ha75500};

  time_interval_counter i_time_interval_counter (
    .i_mclk       (i_mclk),
    .i_sys_rst    (i_sys_rst),
    .i_xtal       (i_xtal),
    .i_sfr        (i_sfr),
    .o_sfr_rdata  (o_sfr_rdata),
    .i_irq_enable (i_irq_enable),
    .i_power_down (i_power_down),
    .o_irq        (o_irq),
    .o_wake       (o_wake)
  );

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Crystal stand-in: one rising edge every two core cycles
  always @(negedge i_mclk) begin
    i_xtal <= ~i_xtal;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Extra idle edge keeps the strobe from being re-raised in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge i_mclk);
    i_sfr.wr = 1'b0;
    @(negedge i_mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    i_sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge i_mclk);
    i_sfr.rd = 1'b0;
    @(negedge i_mclk);
    chk(name, exp, o_sfr_rdata);
  endtask : rd

  // 256 crystal edges per tick, plus margin well short of the next tick
  task automatic ticks(input int n);
    repeat (n * 512 + 40) @(negedge i_mclk);
  endtask : ticks

  initial begin
    repeat (30000) @(posedge i_mclk);
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    i_sys_rst = 1'b1;
    i_sfr = '0;
    i_irq_enable = 1'b1;
    i_power_down = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    for (int a = 'ha1; a <= 'ha7; a++) begin
      rd(8'(a), REG_RESET, "reset_value");
    end
    foreach (ROWS[k]) begin
      wr(ROWS[k][23:16], ROWS[k][15:8]);
      rd(ROWS[k][23:16], ROWS[k][7:0], "register_row");
    end
    // Every counter at its last value, so one tick ripples the whole chain
    wr(TIC_CONTROL_ADDR, 8'h41);
    ticks(1);
    rd(SUBSECOND_ADDR, 8'h00, "subsecond");
    rd(ELAPSED_S_ADDR, 8'h00, "seconds");
    rd(ELAPSED_M_ADDR, 8'h00, "minutes");
    rd(HOUR_COUNT_ADDR, 8'h00, "hour_day");
    wr(TIC_CONTROL_ADDR, 8'h00);
    rd(ELAPSED_S_ADDR, 8'h3b, "seconds_restored");
    wr(TIC_CONTROL_ADDR, 8'h01);
    ticks(1);
    rd(HOUR_COUNT_ADDR, 8'h18, "hour_full");
    for (int tb = 0; tb < 4; tb++) begin
      wr(TIC_CONTROL_ADDR, 8'h00);
      wr(SUBSECOND_ADDR, (tb > 0) ? 8'h7f : 8'h00);
      wr(ELAPSED_S_ADDR, (tb > 1) ? 8'h3b : 8'h00);
      wr(ELAPSED_M_ADDR, (tb > 2) ? 8'h3b : 8'h00);
      wr(INTERVAL_MATCH_ADDR, 8'h01);
      wr(TIC_CONTROL_ADDR, {2'b00, 2'(tb), 4'h3});
      ticks(1);
      rd(TIC_CONTROL_ADDR, {2'b00, 2'(tb), 4'h7}, "timebase_flag");
      chk("irq", 8'h01, {7'h00, o_irq});
    end
    wr(TIC_CONTROL_ADDR, 8'h00);
    wr(INTERVAL_MATCH_ADDR, 8'h02);
    wr(TIC_CONTROL_ADDR, 8'h03);
    ticks(2);
    rd(TIC_CONTROL_ADDR, 8'h07, "match_flag");
    i_irq_enable = 1'b0;
    i_power_down = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("irq_masked", 8'h00, {7'h00, o_irq});
    chk("wake_masked", 8'h00, {7'h00, o_wake});
    i_irq_enable = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("wake", 8'h01, {7'h00, o_wake});
    i_power_down = 1'b0;
    wr(TIC_CONTROL_ADDR, 8'h03);
    rd(TIC_CONTROL_ADDR, 8'h03, "flag_cleared");
    ticks(2);
    rd(TIC_CONTROL_ADDR, 8'h07, "reload_flag");
    wr(TIC_CONTROL_ADDR, 8'h00);
    wr(TIC_CONTROL_ADDR, 8'h0b);
    ticks(2);
    rd(TIC_CONTROL_ADDR, 8'h0d, "one_shot");
    wr(TIC_CONTROL_ADDR, 8'h00);
    wr(TIC_CONTROL_ADDR, 8'h01);
    ticks(2);
    rd(TIC_CONTROL_ADDR, 8'h01, "interval_off");
    chk("irq_idle", 8'h00, {7'h00, o_irq});
    // Second reset in mid-run must clear loaded time
    wr(HOUR_COUNT_ADDR, 8'h05);
    i_sys_rst = 1'b1;
    @(negedge i_mclk);
    i_sys_rst = 1'b0;
    rd(HOUR_COUNT_ADDR, REG_RESET, "hour_after_reset");
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// ---- tic_pkg.sv ----
package tic_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] TIC_CONTROL_ADDR   = 8'ha1;
  localparam logic [7:0] SUBSECOND_ADDR     = 8'ha2;
  localparam logic [7:0] ELAPSED_S_ADDR     = 8'ha3;
  localparam logic [7:0] ELAPSED_M_ADDR     = 8'ha4;
  localparam logic [7:0] HOUR_COUNT_ADDR    = 8'ha5;
  localparam logic [7:0] INTERVAL_MATCH_ADDR = 8'ha6;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Crystal and tick rates
  localparam int unsigned XTAL_HZ       = 32768;
  localparam int unsigned TICK_HZ       = 128;
  localparam int unsigned XTAL_PER_TICK = XTAL_HZ / TICK_HZ;
  localparam logic [7:0]  PRESCALE_LAST = 8'(XTAL_PER_TICK - 1);

  // Counter wrap points
  localparam logic [7:0] SUBSECOND_LAST = 8'h7f;
  localparam logic [7:0] SECOND_LAST    = 8'h3b;
  localparam logic [7:0] MINUTE_LAST    = 8'h3b;
  localparam logic [7:0] DAY_HOUR_LAST  = 8'h17;

  typedef enum logic [1:0] {
    TB_TICK   = 2'b00,
    TB_SECOND = 2'b01,
    TB_MINUTE = 2'b10,
    TB_HOUR   = 2'b11
  } timebase_e;

  typedef struct packed {
    logic      unused_bit;
    logic      day_mode_select;
    timebase_e timebase_select;
    logic      one_shot_mode;
    logic      interval_match_flag;
    logic      interval_enable;
    logic      timekeeping_clock_enable;
  } tic_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_s;

endpackage : tic_pkg

// ---- time_interval_counter.sv ----
// Functional notes
// RL1: Day mode: hour counts 0 to 23
// RL2: Non-day mode: hour counts 0 to 255
// RL3: Timebase field picks tick, second, minute, hour
// RL4: One-shot timeout clears interval enable
// RL5: Auto-reload restarts counter after each timeout
// RL6: Sticky match flag when counter equals match
// RL7: Interrupt request only when interrupt enabled
// RL8: Interval enable gates interval counter
// RL9: Clock disabled: time registers restore written values
// RL10: Time registers writable while clock disabled
// RL11: Clock enabled: counting resumes from loaded values
// RL12: Control bit 7 unimplemented, writes ignored
// RL13: Software keeps match value within 0..255
// RL14: Sub-second counts 0..127 per tick, carries
// RL15: Seconds count 0..59, carry minutes
// RL16: Minutes count 0..59, carry hours
// RL17: Day mode hour advances hourly, wraps 23
// RL18: Interval counter advances on selected rollover
// RL19: Counters run from crystal, through power-down
// RL20: Power-down wake on flag with interrupt enabled
// RL21: Interval counter zeroed on enable and reload
`timescale 1ns/10ps
`default_nettype none
module time_interval_counter (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  // Crystal, sampled as a level
  input  wire logic             i_xtal,
  // Special function register port
  input  wire tic_pkg::sfr_req_s i_sfr,
  output var  logic [7:0]       o_sfr_rdata,
  // System state
  input  wire logic             i_irq_enable,
  input  wire logic             i_power_down,
  // Requests
  output var  logic             o_irq,
  output var  logic             o_wake
);
  import tic_pkg::*;

  tic_ctrl_s  ctrl;
  logic [7:0] subsecond_count;
  logic [7:0] elapsed_s_register;
  logic [7:0] elapsed_m_register;
  logic [7:0] hour_count;
  logic [7:0] interval_match_value;
  logic [7:0] shadow_sub, shadow_s, shadow_m, shadow_h;
  logic [7:0] prescale;
  logic [7:0] interval_count;
  logic       xtal_q;
  logic       enable_q;

  logic       xtal_edge, tick, sub_wrap, s_wrap, m_wrap, advance;
  logic       hour_wrap;
  logic [7:0] next_interval;
  logic       timeout;
  logic       wr_ctrl, wr_sub, wr_s, wr_m, wr_h, wr_match;

  assign wr_ctrl  = i_sfr.wr && (i_sfr.addr == TIC_CONTROL_ADDR);
  assign wr_sub   = i_sfr.wr && (i_sfr.addr == SUBSECOND_ADDR);
  assign wr_s     = i_sfr.wr && (i_sfr.addr == ELAPSED_S_ADDR);
  assign wr_m     = i_sfr.wr && (i_sfr.addr == ELAPSED_M_ADDR);
  assign wr_h     = i_sfr.wr && (i_sfr.addr == HOUR_COUNT_ADDR);
  assign wr_match = i_sfr.wr && (i_sfr.addr == INTERVAL_MATCH_ADDR);

  // Crystal edges form the time base, so the core clock only needs two samples per crystal period [RL19]
  assign xtal_edge = i_xtal && !xtal_q;
  assign tick      = xtal_edge && (prescale == PRESCALE_LAST) && ctrl.timekeeping_clock_enable;
  assign sub_wrap  = tick && (subsecond_count >= SUBSECOND_LAST);
  assign s_wrap    = sub_wrap && (elapsed_s_register >= SECOND_LAST);
  assign m_wrap    = s_wrap && (elapsed_m_register >= MINUTE_LAST);
  assign hour_wrap = ctrl.day_mode_select && (hour_count >= DAY_HOUR_LAST);

  always_comb begin
    case (ctrl.timebase_select) // [RL3] [RL18]
      TB_TICK:   advance = tick;
      TB_SECOND: advance = sub_wrap;
      TB_MINUTE: advance = s_wrap;
      default:   advance = m_wrap;
    endcase
    advance = advance && ctrl.interval_enable; // [RL8]
  end

  assign next_interval = interval_count + 8'h01;
  assign timeout       = advance && (next_interval == interval_match_value);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      xtal_q   <= i_xtal; // Track the pin so release shows no false edge
      prescale <= REG_RESET;
    end else begin
      xtal_q <= i_xtal;
      // Prescaler held while stopped so a restart gives a full first tick
      if (!ctrl.timekeeping_clock_enable) begin
        prescale <= REG_RESET;
      end else if (xtal_edge) begin
        prescale <= prescale + 8'h01;
      end
    end
  end

  // Last values written by software, restored while the clock is off
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      shadow_sub <= REG_RESET;
      shadow_s   <= REG_RESET;
      shadow_m   <= REG_RESET;
      shadow_h   <= REG_RESET;
    end else begin
      if (wr_sub) begin
        shadow_sub <= i_sfr.wdata;
      end
      if (wr_s) begin
        shadow_s <= i_sfr.wdata;
      end
      if (wr_m) begin
        shadow_m <= i_sfr.wdata;
      end
      if (wr_h) begin
        shadow_h <= i_sfr.wdata;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      subsecond_count    <= REG_RESET;
      elapsed_s_register <= REG_RESET;
      elapsed_m_register <= REG_RESET;
      hour_count         <= REG_RESET;
    end else if (!ctrl.timekeeping_clock_enable) begin
      // Writes land directly in the same cycle, otherwise the shadow is restored [RL9] [RL10]
      subsecond_count    <= wr_sub ? i_sfr.wdata : shadow_sub;
      elapsed_s_register <= wr_s ? i_sfr.wdata : shadow_s;
      elapsed_m_register <= wr_m ? i_sfr.wdata : shadow_m;
      hour_count         <= wr_h ? i_sfr.wdata : shadow_h;
    end else begin
      // Counting from whatever was loaded [RL11]
      if (wr_sub) begin
        subsecond_count <= i_sfr.wdata;
      end else if (tick) begin
        subsecond_count <= sub_wrap ? REG_RESET : subsecond_count + 8'h01; // [RL14]
      end
      if (wr_s) begin
        elapsed_s_register <= i_sfr.wdata;
      end else if (sub_wrap) begin
        elapsed_s_register <= s_wrap ? REG_RESET : elapsed_s_register + 8'h01; // [RL15]
      end
      if (wr_m) begin
        elapsed_m_register <= i_sfr.wdata;
      end else if (s_wrap) begin
        elapsed_m_register <= m_wrap ? REG_RESET : elapsed_m_register + 8'h01; // [RL16]
      end
      if (wr_h) begin
        hour_count <= i_sfr.wdata;
      end else if (m_wrap) begin
        // Full range wraps 255 to 0 by overflow [RL1] [RL2] [RL17]
        hour_count <= hour_wrap ? REG_RESET : hour_count + 8'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl <= tic_ctrl_s'(REG_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl <= tic_ctrl_s'(i_sfr.wdata);
        ctrl.unused_bit <= 1'b0; // [RL12]
      end
      // Hardware set beats a software clear in the same cycle [RL6]
      if (timeout) begin
        ctrl.interval_match_flag <= 1'b1;
        if (ctrl.one_shot_mode) begin
          ctrl.interval_enable <= 1'b0; // [RL4]
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      interval_match_value <= REG_RESET;
    end else if (wr_match) begin
      interval_match_value <= i_sfr.wdata; // Full 8 bits accepted [RL13]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      enable_q       <= 1'b0;
      interval_count <= REG_RESET;
    end else begin
      enable_q <= ctrl.interval_enable;
      if (ctrl.interval_enable && !enable_q) begin
        interval_count <= REG_RESET; // [RL21]
      end else if (timeout) begin
        interval_count <= REG_RESET; // [RL5] [RL21]
      end else if (advance) begin
        interval_count <= next_interval;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq  <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_irq  <= ctrl.interval_match_flag && i_irq_enable; // [RL7]
      o_wake <= ctrl.interval_match_flag && i_irq_enable && i_power_down; // [RL20]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= REG_RESET;
    end else if (i_sfr.rd) begin
      if (i_sfr.addr == TIC_CONTROL_ADDR) begin
        o_sfr_rdata <= 8'(ctrl);
      end else if (i_sfr.addr == SUBSECOND_ADDR) begin
        o_sfr_rdata <= subsecond_count;
      end else if (i_sfr.addr == ELAPSED_S_ADDR) begin
        o_sfr_rdata <= elapsed_s_register;
      end else if (i_sfr.addr == ELAPSED_M_ADDR) begin
        o_sfr_rdata <= elapsed_m_register;
      end else if (i_sfr.addr == HOUR_COUNT_ADDR) begin
        o_sfr_rdata <= hour_count;
      end else if (i_sfr.addr == INTERVAL_MATCH_ADDR) begin
        o_sfr_rdata <= interval_match_value;
      end else begin
        o_sfr_rdata <= REG_RESET;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  property p_day_wrap;
    ctrl.timekeeping_clock_enable && m_wrap && !wr_h && ctrl.day_mode_select
      && hour_count == DAY_HOUR_LAST |=> hour_count == REG_RESET;
  endproperty
  a_day_wrap: assert property (p_day_wrap) else $error("hour did not wrap at 23"); // [RL1]

  property p_full_hour;
    m_wrap && !wr_h && !ctrl.day_mode_select && hour_count == 8'h17
      |=> hour_count == 8'h18;
  endproperty
  a_full_hour: assert property (p_full_hour) else $error("hour wrapped early"); // [RL2]

  property p_one_shot;
    timeout && ctrl.one_shot_mode |=> !ctrl.interval_enable && ctrl.interval_match_flag;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot kept enable"); // [RL4]

  property p_reload;
    timeout && !ctrl.one_shot_mode && !wr_ctrl |=> interval_count == REG_RESET
      && ctrl.interval_enable;
  endproperty
  a_reload: assert property (p_reload) else $error("no auto reload"); // [RL5]

  property p_flag_sticky;
    ctrl.interval_match_flag && !wr_ctrl |=> ctrl.interval_match_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // [RL6]

  property p_irq;
    ##1 o_irq == ($past(ctrl.interval_match_flag) && $past(i_irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not tied to flag"); // [RL7]

  property p_gate;
    !ctrl.interval_enable |=> $stable(interval_count);
  endproperty
  a_gate: assert property (p_gate) else $error("counter ran disabled"); // [RL8]

  property p_restore;
    !ctrl.timekeeping_clock_enable && !wr_s ##1 !ctrl.timekeeping_clock_enable
      |-> elapsed_s_register == shadow_s;
  endproperty
  a_restore: assert property (p_restore) else $error("seconds not restored"); // [RL9]

  property p_sub_wrap;
    tick && !wr_sub && subsecond_count == SUBSECOND_LAST |=> subsecond_count == REG_RESET;
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("sub-second wrap wrong"); // [RL14]

  property p_bit7;
    i_sfr.rd && (i_sfr.addr == TIC_CONTROL_ADDR) |=> !o_sfr_rdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 held a value"); // [RL12]

  c_timeout:  cover property (timeout ##2 o_irq);
  c_hour:     cover property (m_wrap && ctrl.day_mode_select);
  c_one_shot: cover property (timeout && ctrl.one_shot_mode);
  c_wake:     cover property (o_wake);

endmodule : time_interval_counter
`default_nettype wire
